// >>> ide_defines.vh
// constants for the instruction decode and execution control block
`ifndef IDE_DEFINES_VH
`define IDE_DEFINES_VH

// instruction cycle: four oscillator periods
`define IDE_PHASE_LAST 2'h3
`define IDE_PHASE_FETCH 2'h1

// instruction classes, word bits 11:10
`define IDE_CLS_BYTE 2'h0
`define IDE_CLS_BIT 2'h1
`define IDE_CLS_JUMP 2'h2
`define IDE_CLS_LIT 2'h3

// byte-oriented opcodes, word bits 11:6
`define IDE_OP_STORE 6'h00
`define IDE_OP_MOVE 6'h02
`define IDE_OP_ADD 6'h03
`define IDE_OP_AND 6'h04
`define IDE_OP_OR 6'h05
`define IDE_OP_XOR 6'h06
`define IDE_OP_INC 6'h07
`define IDE_OP_DEC 6'h08
`define IDE_OP_CLR 6'h09
`define IDE_OP_INCSKZ 6'h0a
`define IDE_OP_DECSKZ 6'h0b

// bit-oriented sub-operations, word bits 9:8
`define IDE_BOP_CLR 2'h0
`define IDE_BOP_SET 2'h1
`define IDE_BOP_SKIPCLR 2'h2
`define IDE_BOP_SKIPSET 2'h3

// logic selector shared by byte and literal operations
`define IDE_LOG_PASS 2'h0
`define IDE_LOG_AND 2'h1
`define IDE_LOG_OR 2'h2
`define IDE_LOG_XOR 2'h3

// special file register indices
`define IDE_F_COUNTER 5'h01
`define IDE_F_PC 5'h02
`define IDE_F_PORT_A 5'h05
`define IDE_F_PORT_B 5'h06
`define IDE_F_PORT_C 5'h07
`define IDE_F_BANKED 4

// reset values
`define IDE_PC_RESET 11'h7ff
`define IDE_TRISTATE_LOAD_INSTR_RESET 8'hff
`define IDE_ACC_RESET 8'h00

`endif

// >>> ide_core.v
// instruction decode and execution control for a 12-bit instruction word
// Overview of operation
// - fetch 12-bit word, split opcode and operands
// - register field picks one of 32 files
// - pointer bits 5,6 select bank when banked
// - destination zero to accumulator, one to file
// - bit field picks bit, register field file
// - literal ops take 8 or 9 bit constant
// - one cycle; two on skip or branch
// - four oscillator periods per instruction cycle
// - program counter file writes clear bits 9 and 8
// - port read-modify uses pin levels
// - tristate load copies accumulator to direction latches
// - counter file write clears assigned prescaler
`timescale 1ns/1ps
`include "ide_defines.vh"

module ide_core (
  input wire ref_clk, // oscillator clock
  input wire sys_rst, // synchronous reset, active high
  input wire clk_en, // freezes all state while low
  input wire [11:0] instr_word, // word from program memory
  input wire [7:0] file_rdata, // data of addressed file register
  input wire [7:0] indirect_pointer, // pointer register contents
  input wire bank_enable, // banked family member
  input wire prescaler_to_counter, // prescaler assigned to counter
  input wire [7:0] port_a_pins, // port a pin levels
  input wire [7:0] port_b_pins, // port b pin levels
  input wire [7:0] port_c_pins, // port c pin levels
  output wire [10:0] program_counter, // fetch address
  output wire [6:0] file_addr, // file register address
  output wire file_we, // one-cycle file write strobe
  output wire [7:0] file_wdata, // file write data
  output wire [7:0] acc, // accumulator
  output wire [7:0] tristate_load_instr_a, // port a direction latches
  output wire [7:0] tristate_load_instr_b, // port b direction latches
  output wire [7:0] tristate_load_instr_c, // port c direction latches
  output wire prescaler_clr, // one-cycle prescaler clear
  output wire cycle_end, // pulse in last period of a cycle
  output wire exec_idle, // second cycle of a two-cycle op
  output wire [5:0] dec_opcode, // decoded opcode field
  output wire dec_dest, // decoded destination bit
  output wire [4:0] dec_reg, // decoded register designator
  output wire [2:0] dec_bit, // decoded bit number
  output wire [8:0] dec_lit // decoded literal
);

  reg [1:0] phase_reg;
  reg [11:0] ir_reg;
  reg [10:0] pc_reg;
  reg [7:0] acc_reg;
  reg [6:0] file_addr_reg;
  reg file_we_reg;
  reg [7:0] file_wdata_reg;
  reg [23:0] tristate_load_instr_reg;
  reg prescaler_clr_reg;
  reg cycle_end_reg;
  reg idle_reg;
  reg [23:0] pin_s1_reg;
  reg [23:0] pin_s2_reg;
  reg [23:0] pin_s3_reg;
  reg [23:0] pin_q_reg;

  // field decode of the held word
  wire [1:0] cls = ir_reg[11:10];
  wire [5:0] op6 = ir_reg[11:6];
  wire d_bit = ir_reg[5];
  wire [4:0] f_idx = ir_reg[4:0];
  wire [2:0] b_idx = ir_reg[7:5];
  wire [1:0] bop = ir_reg[9:8];
  wire [7:0] k8 = ir_reg[7:0];
  wire [8:0] k9 = ir_reg[8:0];

  // logic operation shared by byte and literal classes
  function [7:0] ide_logic;
    input [1:0] sel;
    input [7:0] a;
    input [7:0] b;
    begin
      case (sel)
        `IDE_LOG_AND: ide_logic = a & b;
        `IDE_LOG_OR: ide_logic = a | b;
        `IDE_LOG_XOR: ide_logic = a ^ b;
        default: ide_logic = b;
      endcase
    end
  endfunction

  // port register test
  function ide_is_port;
    input [4:0] f;
    begin
      ide_is_port = (f == `IDE_F_PORT_A) || (f == `IDE_F_PORT_B) ||
        (f == `IDE_F_PORT_C);
    end
  endfunction

  // bank-aware file address
  function [6:0] ide_faddr;
    input [4:0] f;
    input [7:0] ptr;
    input banked;
    begin
      if (banked && f[`IDE_F_BANKED])
        ide_faddr = {ptr[6:5], f};
      else
        ide_faddr = {2'h0, f};
    end
  endfunction

  // operand source: pins for ports, counter for pc, else file
  reg [7:0] src;
  always @*
  begin
    case (f_idx)
      `IDE_F_PORT_A: src = pin_q_reg[7:0];
      `IDE_F_PORT_B: src = pin_q_reg[15:8];
      `IDE_F_PORT_C: src = pin_q_reg[23:16];
      `IDE_F_PC: src = pc_reg[7:0];
      default: src = file_rdata;
    endcase
  end

  // execution: result, destination, skip and branch
  reg [7:0] res;
  reg wr_file;
  reg wr_acc;
  reg wr_tristate_load_instr;
  reg skip;
  reg jump;
  reg [10:0] jump_pc;
  reg [7:0] mask;
  always @*
  begin
    res = 8'h00;
    wr_file = 1'b0;
    wr_acc = 1'b0;
    wr_tristate_load_instr = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    jump_pc = pc_reg;
    mask = 8'h01 << b_idx;
    case (cls)
      `IDE_CLS_BYTE:
      begin
        wr_file = d_bit;
        wr_acc = ~d_bit;
        case (op6)
          `IDE_OP_STORE:
          begin
            res = acc_reg;
            wr_acc = 1'b0;
            wr_tristate_load_instr = ~d_bit && ide_is_port(f_idx);
          end
          `IDE_OP_MOVE: res = src;
          `IDE_OP_ADD: res = src + acc_reg;
          `IDE_OP_AND: res = ide_logic(`IDE_LOG_AND, acc_reg, src);
          `IDE_OP_OR: res = ide_logic(`IDE_LOG_OR, acc_reg, src);
          `IDE_OP_XOR: res = ide_logic(`IDE_LOG_XOR, acc_reg, src);
          `IDE_OP_INC: res = src + 8'h01;
          `IDE_OP_DEC: res = src - 8'h01;
          `IDE_OP_CLR: res = 8'h00;
          `IDE_OP_INCSKZ:
          begin
            res = src + 8'h01;
            skip = (res == 8'h00);
          end
          `IDE_OP_DECSKZ:
          begin
            res = src - 8'h01;
            skip = (res == 8'h00);
          end
          default:
          begin
            wr_file = 1'b0;
            wr_acc = 1'b0;
          end
        endcase
      end
      `IDE_CLS_BIT:
      begin
        case (bop)
          `IDE_BOP_CLR:
          begin
            res = src & ~mask;
            wr_file = 1'b1;
          end
          `IDE_BOP_SET:
          begin
            res = src | mask;
            wr_file = 1'b1;
          end
          `IDE_BOP_SKIPCLR: skip = ((src & mask) == 8'h00);
          default: skip = ((src & mask) != 8'h00);
        endcase
      end
      `IDE_CLS_JUMP:
      begin
        jump = 1'b1;
        if (ir_reg[9])
          jump_pc = {pc_reg[10:9], k9};
        else
          jump_pc = {pc_reg[10], 2'h0, k8};
      end
      default:
      begin
        res = ide_logic(bop, acc_reg, k8);
        wr_acc = 1'b1;
      end
    endcase
    // a file write that lands on the program counter is a branch
    if (wr_file && f_idx == `IDE_F_PC)
    begin
      wr_file = 1'b0;
      jump = 1'b1;
      jump_pc = {pc_reg[10], 2'h0, res};
    end
  end

  // three-flop pin synchroniser, value taken when stages 2 and 3 agree
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pin_s1_reg <= 24'h000000;
      pin_s2_reg <= 24'h000000;
      pin_s3_reg <= 24'h000000;
      pin_q_reg <= 24'h000000;
    end
    else if (clk_en)
    begin
      pin_s1_reg <= {port_c_pins, port_b_pins, port_a_pins};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // take stage 3 only where stages 2 and 3 agree, else hold
      pin_q_reg <= (pin_s3_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
        (pin_q_reg & (pin_s2_reg ^ pin_s3_reg));
    end
  end

  // phase sequencer, fetch and execute
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      phase_reg <= 2'h0;
      ir_reg <= 12'h000;
      pc_reg <= `IDE_PC_RESET;
      acc_reg <= `IDE_ACC_RESET;
      file_addr_reg <= 7'h00;
      file_we_reg <= 1'b0;
      file_wdata_reg <= 8'h00;
      tristate_load_instr_reg <= {3{`IDE_TRISTATE_LOAD_INSTR_RESET}};
      prescaler_clr_reg <= 1'b0;
      cycle_end_reg <= 1'b0;
      idle_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_reg <= phase_reg + 2'h1;
      file_we_reg <= 1'b0;
      prescaler_clr_reg <= 1'b0;
      cycle_end_reg <= (phase_reg == `IDE_PHASE_LAST - 2'h1);
      if (phase_reg == `IDE_PHASE_FETCH && !idle_reg)
      begin
        ir_reg <= instr_word;
        file_addr_reg <= ide_faddr(instr_word[4:0], indirect_pointer,
          bank_enable);
      end
      if (phase_reg == `IDE_PHASE_LAST)
      begin
        if (idle_reg)
          idle_reg <= 1'b0;
        else
        begin
          if (wr_acc)
            acc_reg <= res;
          if (wr_file)
          begin
            file_we_reg <= 1'b1;
            file_wdata_reg <= res;
            if (f_idx == `IDE_F_COUNTER && prescaler_to_counter)
              prescaler_clr_reg <= 1'b1;
          end
          if (wr_tristate_load_instr)
          begin
            case (f_idx)
              `IDE_F_PORT_A: tristate_load_instr_reg[7:0] <= acc_reg;
              `IDE_F_PORT_B: tristate_load_instr_reg[15:8] <= acc_reg;
              default: tristate_load_instr_reg[23:16] <= acc_reg;
            endcase
          end
          if (jump)
            pc_reg <= jump_pc;
          else if (skip)
            pc_reg <= pc_reg + 11'h002;
          else
            pc_reg <= pc_reg + 11'h001;
          idle_reg <= jump | skip;
        end
      end
    end
  end

  // outputs straight from flip-flops
  assign program_counter = pc_reg;
  assign file_addr = file_addr_reg;
  assign file_we = file_we_reg;
  assign file_wdata = file_wdata_reg;
  assign acc = acc_reg;
  assign tristate_load_instr_a = tristate_load_instr_reg[7:0];
  assign tristate_load_instr_b = tristate_load_instr_reg[15:8];
  assign tristate_load_instr_c = tristate_load_instr_reg[23:16];
  assign prescaler_clr = prescaler_clr_reg;
  assign cycle_end = cycle_end_reg;
  assign exec_idle = idle_reg;
  assign dec_opcode = ir_reg[11:6];
  assign dec_dest = ir_reg[5];
  assign dec_reg = ir_reg[4:0];
  assign dec_bit = ir_reg[7:5];
  assign dec_lit = ir_reg[8:0];

endmodule // ide_core

// >>> ide_unused_placeholder_removed.v
// intentionally empty module-free file holding no logic
`timescale 1ns/1ps

// >>> ide_core_chk.sv
// assertion checker for the instruction decode core
`timescale 1ns/1ps
module ide_core_chk (
  input logic ref_clk, // clock
  input logic sys_rst, // reset
  input logic clk_en, // clock enable
  input logic [11:0] instr_word, // fetched word
  input logic [7:0] indirect_pointer, // bank source
  input logic bank_enable, // banked member
  input logic prescaler_to_counter, // prescaler owner
  input logic [6:0] file_addr, // file address
  input logic file_we, // write strobe
  input logic [7:0] acc, // accumulator
  input logic [7:0] tristate_load_instr_a, // direction a
  input logic [7:0] tristate_load_instr_b, // direction b
  input logic [7:0] tristate_load_instr_c, // direction c
  input logic prescaler_clr, // prescaler clear
  input logic cycle_end, // phase 3 marker
  input logic exec_idle, // idle cycle
  input logic [5:0] dec_opcode, // opcode field
  input logic dec_dest, // destination bit
  input logic [4:0] dec_reg // register field
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  // bank bits of the pointer
  wire [1:0] bank_bits = indirect_pointer[6:5];
  chk_cycle_four: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("cycle length not four");
  chk_we_after_end: assert property (file_we |-> $past(cycle_end))
    else $error("file write outside cycle end");
  chk_we_single: assert property (file_we |=> !file_we)
    else $error("file write longer than one clock");
  // owner is taken at the executing edge, one clock before the strobe
  chk_psc_only: assert property (prescaler_clr |->
    file_we && file_addr == 7'h01 && $past(prescaler_to_counter))
    else $error("prescaler cleared without cause");
  chk_psc_when: assert property (file_we && file_addr == 7'h01 &&
    $past(prescaler_to_counter) |-> prescaler_clr)
    else $error("prescaler not cleared");
  chk_dec_slice: assert property (cycle_end && !exec_idle |->
    {dec_opcode, dec_dest, dec_reg} == $past(instr_word, 2))
    else $error("decoded fields wrong");
  chk_bank_sel: assert property (cycle_end && !exec_idle && !dec_opcode[5] |->
    file_addr == ((bank_enable && dec_reg[4]) ? {$past(bank_bits, 2), dec_reg} :
    {2'h0, dec_reg}))
    else $error("file address wrong");
  chk_idle_len: assert property ($rose(exec_idle) |-> exec_idle [*4] ##1 !exec_idle)
    else $error("idle cycle not four clocks");
  chk_tristate_load_instr_acc: assert property ((!$changed(tristate_load_instr_a) || tristate_load_instr_a == acc) &&
    (!$changed(tristate_load_instr_b) || tristate_load_instr_b == acc) && (!$changed(tristate_load_instr_c) || tristate_load_instr_c == acc))
    else $error("direction latch not from accumulator");
endmodule // ide_core_chk
bind ide_core ide_core_chk u_chk (.ref_clk, .sys_rst, .clk_en, .instr_word, .indirect_pointer,
  .bank_enable, .prescaler_to_counter, .file_addr, .file_we, .acc, .tristate_load_instr_a, .tristate_load_instr_b,
  .tristate_load_instr_c, .prescaler_clr, .cycle_end, .exec_idle, .dec_opcode, .dec_dest, .dec_reg);

// >>> ide_pmem.sv
// program memory model holding the test program
`timescale 1ns/1ps
module ide_pmem (
  input wire [10:0] program_counter, // fetch address
  output wire [11:0] instr_word // word at address
);
  reg [11:0] mem [0:2047];
  integer i;
  // unknown opcode as filler, then the program
  initial
  begin
    for (i = 0; i < 2048; i = i + 1)
      mem[i] = 12'h3c0;
    mem[11'h7ff] = 12'ha00;
    mem[11'h600] = 12'hc5a;
    mem[11'h601] = 12'hfff;
    mem[11'h602] = 12'h006;
    mem[11'h603] = 12'h0a6;
    mem[11'h604] = 12'h0c9;
    mem[11'h605] = 12'h021;
    mem[11'h606] = 12'h561;
    mem[11'h607] = 12'h709;
    mem[11'h609] = 12'h022;
    mem[11'h4b6] = 12'h099;
  end
  // word always driven from the array
  assign instr_word = mem[program_counter];
endmodule // ide_pmem

// >>> tb_top.sv
// testbench running a short program through the core
`timescale 1ns/1ps
module tb_top;
  reg ref_clk, sys_rst, clk_en, bank_enable, prescaler_to_counter;
  reg [7:0] file_rdata, indirect_pointer, port_a_pins, port_b_pins, port_c_pins;
  wire [11:0] instr_word;
  wire [10:0] program_counter;
  wire [6:0] file_addr;
  wire [7:0] file_wdata, acc, tristate_load_instr_a, tristate_load_instr_b, tristate_load_instr_c;
  wire [5:0] dec_opcode;
  wire [4:0] dec_reg;
  wire file_we, prescaler_clr, cycle_end, exec_idle, dec_dest;
  wire [2:0] dec_bit;
  wire [8:0] dec_lit;
  integer errors = 0;
  integer cmp_count = 0;
  integer cycles = 0;
  ide_pmem u_pmem (.program_counter, .instr_word);
  ide_core DUT (.ref_clk, .sys_rst, .clk_en, .instr_word, .file_rdata, .indirect_pointer,
    .bank_enable, .prescaler_to_counter, .port_a_pins, .port_b_pins, .port_c_pins,
    .program_counter, .file_addr, .file_we, .file_wdata, .acc, .tristate_load_instr_a, .tristate_load_instr_b, .tristate_load_instr_c,
    .prescaler_clr, .cycle_end, .exec_idle, .dec_opcode, .dec_dest, .dec_reg,
    .dec_bit, .dec_lit);
  // clock, 20 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // prints counts and verdict, ends run
  task final_report;
  begin
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // compares one value
  task chk(input [95:0] name, input [11:0] exp, input [11:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0s exp %h got %h", name, exp, got);
    end
  end
  endtask
  // runs to the negedge after one cycle end
  task step;
    integer n;
  begin
    n = 0;
    while (cycle_end !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    if (n == 8)
      chk("cycle_end", 12'h1, {11'h0, cycle_end});
    @(negedge ref_clk);
  end
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      final_report;
    end
  end
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    bank_enable = 1'b1;
    prescaler_to_counter = 1'b1;
    file_rdata = 8'h11;
    indirect_pointer = 8'h60;
    port_a_pins = 8'h00;
    port_b_pins = 8'h3c;
    port_c_pins = 8'h00;
    repeat (16) @(negedge ref_clk);
    chk("tristate_load_instr_reset", 12'h0ff, tristate_load_instr_b);
    sys_rst = 1'b0;
    step;
    chk("jump_pc", 12'h600, program_counter);
    chk("jump_idle", 12'h1, exec_idle);
    step;
    chk("idle_end", 12'h0, exec_idle);
    step;
    chk("lit_move", 12'h05a, acc);
    chk("one_cycle", 12'h601, program_counter);
    chk("lit_field", 12'h05a, dec_lit);
    step;
    chk("lit_xor", 12'h0a5, acc);
    // enable held low mid-cycle: the tristate load must wait
    @(negedge ref_clk);
    clk_en = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("freeze_pc", 12'h602, program_counter);
    chk("freeze_tristate_load_instr", 12'h0ff, tristate_load_instr_b);
    clk_en = 1'b1;
    step;
    chk("tristate_load_instr_b", 12'h0a5, tristate_load_instr_b);
    chk("tristate_load_instr_a", 12'h0ff, tristate_load_instr_a);
    step;
    chk("pin_src", 12'h03c, file_wdata);
    chk("dest_file", 12'h1, file_we);
    chk("addr6", 12'h006, file_addr);
    step;
    chk("dest_acc", 12'h0b6, acc);
    chk("no_write", 12'h0, file_we);
    step;
    chk("psc_clr", 12'h1, prescaler_clr);
    chk("store", 12'h0b6, file_wdata);
    prescaler_to_counter = 1'b0;
    step;
    chk("bit_set", 12'h019, file_wdata);
    chk("bit_field", 12'h003, dec_bit);
    chk("psc_keep", 12'h0, prescaler_clr);
    step;
    chk("skip_pc", 12'h609, program_counter);
    chk("skip_idle", 12'h1, exec_idle);
    step;
    step;
    chk("pc_bit9", 12'h4b6, program_counter);
    chk("pc_idle", 12'h1, exec_idle);
    step;
    step;
    chk("bank_addr", 12'h079, file_addr);
    chk("bank_acc", 12'h011, acc);
    final_report;
  end
endmodule // tb_top
